// ---- rtl/tvtrg_pkg.sv ----
/*
  Package for the television line trigger logic: address map of the paged
  window, register field positions, counter register selects and mode codes.
  Assumes a 16-bit host address bus and 8-bit data bus.
*/
package tvtrg_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [15:0] WIN_LO       = 16'h4000;
  localparam logic [15:0] WIN_HI       = 16'h7fff;
  localparam logic [15:0] ROM_LO       = 16'h4000;
  localparam logic [15:0] ROM_HI       = 16'h5fff;
  localparam logic [15:0] ROM_IMG_LO   = 16'h6000;
  localparam logic [15:0] ROM_IMG_HI   = 16'h7f7f;
  localparam logic [15:0] CTR_LO       = 16'h7f80;
  localparam logic [15:0] CTR_HI       = 16'h7f87;
  localparam logic [15:0] CTR_IMG_LO   = 16'h7f90;
  localparam logic [15:0] CTR_IMG_HI   = 16'h7f97;
  localparam logic [15:0] CTRL_IMG_LO  = 16'h7f88;
  localparam logic [15:0] CTRL_ADDR    = 16'h7f8f;
  localparam logic [15:0] CTRL_IMG2_LO = 16'h7fa8;
  localparam logic [15:0] CTRL_IMG2_HI = 16'h7faf;
  localparam logic [15:0] MODE_IMG_LO  = 16'h7f98;
  localparam logic [15:0] MODE_ADDR    = 16'h7f9f;
  localparam logic [15:0] MODE_IMG2_LO = 16'h7fb8;
  localparam logic [15:0] MODE_IMG2_HI = 16'h7fbf;
  localparam logic [15:0] OPT_IMG_LO   = 16'h7fc0;
  localparam logic [15:0] OPT_ADDR     = 16'h7fff;

  localparam int ROM_AW      = 13;
  localparam int ADDR_BIT14  = 14;
  localparam int ADDR_BIT3   = 3;
  localparam int OPT_EN_BIT  = 5;

  // ****************************************************************
  // Register fields
  // ****************************************************************
  localparam int MODE_ALT_BIT   = 0;
  localparam int MODE_SWAP_BIT  = 1;
  localparam int MODE_LINES_BIT = 2;

  localparam int CTL_LINES_BIT  = 0;
  localparam int CTL_FIRST_HALF_COUPLING_BIT   = 1;
  localparam int CTL_SECOND_HALF_COUPLING_BIT   = 2;
  localparam int CTL_SYNC_TIP_POLARITY_BIT  = 3;
  localparam int CTL_INV_BIT    = 4;
  localparam int CTL_CLAMP_BIT  = 5;
  localparam int CTL_FAST_BIT   = 6;
  localparam int CTL_AUXEN_BIT  = 7;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Counter select: bits 2:1 pick counter, bit 0 picks low/high byte
  localparam logic [1:0] CSEL_C1 = 2'h0;
  localparam logic [1:0] CSEL_C2 = 2'h1;
  localparam logic [1:0] CSEL_C3 = 2'h2;
  localparam logic [1:0] CSEL_ST = 2'h3;

  // Trigger control outputs travel together
  typedef struct packed {
    logic aux_enable;
    logic clamp_fast;
    logic clamp_on;
    logic second_channel_flip;
    logic sync_tip_polarity;
    logic second_half_coupling;
    logic first_half_coupling;
    logic lines_coupling;
  } tvtrg_ctl_t;

  typedef enum logic [1:0] {
    CT_IDLE  = 2'b00,
    CT_WAIT  = 2'b01,
    CT_COUNT = 2'b10,
    CT_DONE  = 2'b11
  } tvtrg_ct_state_t;

endpackage

// ---- rtl/tvtrg_line_counter.sv ----
/*
  One single-shot line counter. Counts line clock edges while gated,
  the first gated edge only starts the count. Output goes low one line
  after the count reaches zero. Assumes a one-cycle line_tick pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tvtrg_line_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         gate,
  input  wire logic         line_tick,
  output logic              out_low,
  output logic [W-1:0]      count
);

  // A one-bit count cannot hold a delay
  if (W < 2) begin : g_bad_w
    $error("counter width too small");
  end

  tvtrg_pkg::tvtrg_ct_state_t st_q, st_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic         gate_q;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      tvtrg_pkg::CT_IDLE: begin
      end
      // Edge at field start only starts counting
      tvtrg_pkg::CT_WAIT: begin
        if (gate && !gate_q) st_d = tvtrg_pkg::CT_COUNT;
      end
      tvtrg_pkg::CT_COUNT: begin
        if (line_tick) begin
          if (cnt_q == '0) st_d = tvtrg_pkg::CT_DONE;
          else cnt_d = cnt_q - 1'b1;
        end
      end
      tvtrg_pkg::CT_DONE: begin
        if (line_tick) st_d = tvtrg_pkg::CT_IDLE;
      end
      default: st_d = tvtrg_pkg::CT_IDLE;
    endcase
    if (load) begin
      st_d  = tvtrg_pkg::CT_WAIT;
      // Zero delay is not allowed, a load of zero acts as two
      cnt_d = (load_value == '0) ? W'(1) : load_value - 1'b1;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q   <= tvtrg_pkg::CT_IDLE;
      cnt_q  <= '0;
      gate_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      gate_q <= gate;
    end
  end

  assign out_low = (st_q == tvtrg_pkg::CT_DONE);
  assign count   = cnt_q;

endmodule
`default_nettype wire

// ---- rtl/tvtrg_top.sv ----
/*
  Digital section of a television line trigger add-on: paged window
  decode, data buffer and ROM enables, write-only control and mode
  registers, three line counters and the auxiliary trigger generator.
  Assumes host strobes and the line clock are synchronous to clk.
// What this block does
// - Write to top window address latches data bit 5 as option enable.
// - Option enable high selects the window; low deselects the device.
// - Deselected, only option enable register and its mirrors respond.
// - Option enable register decodes from 7fc0 up to 7fff.
// - Trigger control decodes at 7f8f and two mirrors, only when selected.
// - Mode select decodes at 7f9f and two mirror ranges.
// - Counters enabled in their range with address bit three low.
// - ROM data driven for ROM range and its image when selected.
// - Data buffer enabled by valid access, bit 14, option; direction by r/w.
// - Counters 1 and 2 delay from field starts; counter 3 counts lines.
// - Counters 1 and 3 gated by field flag, counter 2 by inverse.
// - Counters 1 and 2 pulse low at the line before the selected one.
// - Field-pulse edge only starts count; no zero delay; low after zero.
// - Holdoff high holds arming and trigger flip-flops reset.
// - Once armed, trigger fires on next line clock rising edge.
// - Every-line mode arms as soon as holdoff falls.
// - Field modes: either counter pulse arms the trigger.
// - Alternating mode: sweep phase passes only one counter to arm.
// - Order swap inverts sweep phase in alternating mode.
// - Field flag high in field one, low in field two.
*/
`timescale 1ns/1ps
`default_nettype none
module tvtrg_top #(
  parameter int CW = 16
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [15:0]       addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              valid_memory_access,
  input  wire logic              host_read_write,
  input  wire logic              line_clock,
  input  wire logic              field_flag,
  input  wire logic              sweep_holdoff,
  input  wire logic              sweep_phase,
  output logic                   buf_enable,
  output logic                   buf_dir_to_host,
  output logic                   rom_enable,
  output logic [12:0]            rom_addr,
  output logic                   ctr_enable,
  output logic [7:0]             ctr_rdata,
  output tvtrg_pkg::tvtrg_ctl_t  ctl,
  output logic                   option_selected,
  output logic                   aux_trigger
);

  // Read back and load registers are two bytes wide
  if (CW < 8 || CW > 16) begin : g_bad_cw
    $error("counter width must be 8 to 16");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire in_win  = addr >= tvtrg_pkg::WIN_LO && addr <= tvtrg_pkg::WIN_HI;
  wire opt_hit = addr >= tvtrg_pkg::OPT_IMG_LO && addr <= tvtrg_pkg::OPT_ADDR;
  wire rom_hit = (addr >= tvtrg_pkg::ROM_LO && addr <= tvtrg_pkg::ROM_HI)
              || (addr >= tvtrg_pkg::ROM_IMG_LO && addr <= tvtrg_pkg::ROM_IMG_HI);
  wire ctl_hit = (addr >= tvtrg_pkg::CTRL_IMG_LO && addr <= tvtrg_pkg::CTRL_ADDR)
              || (addr >= tvtrg_pkg::CTRL_IMG2_LO && addr <= tvtrg_pkg::CTRL_IMG2_HI);
  wire mod_hit = (addr >= tvtrg_pkg::MODE_IMG_LO && addr <= tvtrg_pkg::MODE_ADDR)
              || (addr >= tvtrg_pkg::MODE_IMG2_LO && addr <= tvtrg_pkg::MODE_IMG2_HI);
  wire ctr_rng = addr >= tvtrg_pkg::CTR_LO && addr <= tvtrg_pkg::CTR_IMG_HI;
  wire acc     = valid_memory_access && in_win;
  wire wr      = acc && !host_read_write;

  logic       opt_q;
  logic [7:0] ctl_q;
  logic [2:0] mode_q;

  // Everything but the option register waits for selection
  wire sel       = opt_q;
  wire opt_wr    = wr && opt_hit;
  wire ctl_wr    = wr && sel && ctl_hit;
  wire mod_wr    = wr && sel && mod_hit;
  wire ctr_sel   = acc && sel && ctr_rng && !addr[tvtrg_pkg::ADDR_BIT3];
  wire ctr_wr    = ctr_sel && !host_read_write;

  assign buf_enable      = valid_memory_access && addr[tvtrg_pkg::ADDR_BIT14] && sel;
  assign buf_dir_to_host = host_read_write;
  assign rom_enable      = acc && sel && rom_hit && host_read_write;
  assign rom_addr        = addr[tvtrg_pkg::ROM_AW-1:0];
  assign ctr_enable      = ctr_sel;
  assign option_selected = opt_q;
  assign ctl             = ctl_q;

  // ****************************************************************
  // Write-only registers, cleared at reset
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opt_q  <= 1'b0;
      ctl_q  <= tvtrg_pkg::REG_RESET;
      mode_q <= 3'h0;
    end else begin
      if (opt_wr) opt_q <= wdata[tvtrg_pkg::OPT_EN_BIT];
      if (ctl_wr) ctl_q <= wdata;
      if (mod_wr) mode_q <= {wdata[tvtrg_pkg::MODE_LINES_BIT],
                             wdata[tvtrg_pkg::MODE_SWAP_BIT],
                             wdata[tvtrg_pkg::MODE_ALT_BIT]};
    end
  end

  wire m_alt   = mode_q[0];
  wire m_swap  = mode_q[1];
  wire m_lines = mode_q[2];

  // ****************************************************************
  // Counter load registers, low and high byte per counter
  // ****************************************************************
  logic [15:0] ld_val_q [3];
  logic [2:0]  load_q;
  wire  [1:0]  csel = addr[2:1];
  logic        line_q;
  wire         line_tick = line_clock && !line_q;
  logic [2:0]  cnt_out_low;
  logic [CW-1:0] cnt_val [3];
  wire  [2:0]  gates = {field_flag, !field_flag, field_flag};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ctr
      // High byte write completes the load value and starts the shot
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ld_val_q[gi] <= 16'h0000;
          load_q[gi]   <= 1'b0;
        end else begin
          load_q[gi] <= ctr_wr && csel == 2'(gi) && addr[0];
          if (ctr_wr && csel == 2'(gi)) begin
            if (addr[0]) ld_val_q[gi][15:8] <= wdata;
            else ld_val_q[gi][7:0] <= wdata;
          end
        end
      end

      tvtrg_line_counter #(.W(CW)) u_cnt (
        .clk        (clk),
        .reset      (reset),
        .load       (load_q[gi]),
        .load_value (ld_val_q[gi][CW-1:0]),
        .gate       (gates[gi]),
        .line_tick  (line_tick && gates[gi]),
        .out_low    (cnt_out_low[gi]),
        .count      (cnt_val[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Counter read back, registered
  // ****************************************************************
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    case (csel)
      tvtrg_pkg::CSEL_C1: rd_word = 16'(cnt_val[0]);
      tvtrg_pkg::CSEL_C2: rd_word = 16'(cnt_val[1]);
      tvtrg_pkg::CSEL_C3: rd_word = 16'(cnt_val[2]);
      tvtrg_pkg::CSEL_ST: rd_word = {13'h0000, cnt_out_low};
      default:            rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctr_rdata <= 8'h00;
      line_q    <= 1'b0;
    end else begin
      line_q <= line_clock;
      if (ctr_sel && host_read_write) ctr_rdata <= addr[0] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  // ****************************************************************
  // Mode select and trigger generator
  // ****************************************************************
  // Order swap inverts sweep phase before it picks a field counter
  wire phase   = sweep_phase ^ m_swap;
  wire c1_pass = cnt_out_low[0] && (!m_alt || phase);
  wire c2_pass = cnt_out_low[1] && (!m_alt || !phase);
  wire arm_set = m_lines ? 1'b1 : (c1_pass || c2_pass);

  logic arm_q;
  logic trig_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_q  <= 1'b0;
      trig_q <= 1'b0;
    end else if (sweep_holdoff) begin
      arm_q  <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (arm_set) arm_q <= 1'b1;
      if (arm_q && line_tick) trig_q <= 1'b1;
    end
  end

  // Gated by the aux enable so a cleared aux enable bit never fires the sweep
  assign aux_trigger = trig_q && ctl_q[tvtrg_pkg::CTL_AUXEN_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_HOLDOFF: assert property (@(posedge clk) disable iff (reset)
    sweep_holdoff |=> !arm_q && !trig_q) else $error("holdoff did not clear");
  AST_FIRE: assert property (@(posedge clk) disable iff (reset)
    arm_q && line_tick && !sweep_holdoff |=> trig_q) else $error("armed trigger missed");
  AST_LINES: assert property (@(posedge clk) disable iff (reset)
    m_lines && !sweep_holdoff |=> arm_q) else $error("lines mode not armed");
  AST_DESEL: assert property (@(posedge clk) disable iff (reset)
    !opt_q |-> !buf_enable && !rom_enable && !ctr_enable) else $error("deselected access");
  AST_OPTWR: assert property (@(posedge clk) disable iff (reset)
    opt_wr |=> opt_q == $past(wdata[tvtrg_pkg::OPT_EN_BIT])) else $error("option bit not latched");
  AST_CTLWR: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |=> ctl_q == $past(wdata)) else $error("control not written");
  AST_NOARM: assert property (@(posedge clk) disable iff (reset)
    !arm_q |=> !trig_q) else $error("trigger without arming");
  AST_ALT: assert property (@(posedge clk) disable iff (reset)
    m_alt && !m_lines && !phase && !cnt_out_low[1] && !arm_q && !sweep_holdoff
    |=> !arm_q) else $error("alt passed wrong counter");

endmodule
`default_nettype wire

// ---- dv/tvtrg_video_model.sv ----
/*
  Far-side video source model: free-running line clock and field flag.
  Assumes the bench clock; lines are shortened to keep the run brief.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Video source
// ****************************************************************
module tvtrg_video_model #(
  parameter int LP = 8,
  parameter int FL = 12
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      line_clock,
  output logic      field_flag
);
  int cyc;
  int line;
  // Field changes together with a line rise, like the field pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cyc <= 0;
      line <= 0;
      line_clock <= 1'b0;
      field_flag <= 1'b0;
    end else begin
      cyc <= (cyc == LP - 1) ? 0 : cyc + 1;
      line_clock <= (cyc == LP - 1) || (cyc == 0);
      if (cyc == LP - 1) begin
        line <= (line == FL - 1) ? 0 : line + 1;
        if (line == FL - 1) field_flag <= ~field_flag;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_tv_line_trigger_logic.sv ----
/*
  Self-checking bench for the line trigger logic: decode, registers,
  counter arming and trigger modes. Assumes the video model file.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_tv_line_trigger_logic;
  logic clk, reset, vma, rw, ph, hold, line_clock, field_flag;
  logic [15:0] addr;
  logic [7:0]  wdata, d, ctr_rdata;
  logic        buf_en, dir, rom_en, ctr_en, opt, aux;
  logic [12:0] rom_addr;
  tvtrg_pkg::tvtrg_ctl_t ctl;
  int n_errors, checks, i, n;
  logic [15:0] corner[10] = '{16'h3fff, 16'h4000, 16'h5fff, 16'h6000, 16'h7f7f,
                             16'h7f80, 16'h7f87, 16'h7f88, 16'h7f97, 16'h7f98};
  tvtrg_top dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .valid_memory_access(vma), .host_read_write(rw), .line_clock(line_clock),
    .field_flag(field_flag), .sweep_holdoff(hold), .sweep_phase(ph),
    .buf_enable(buf_en), .buf_dir_to_host(dir), .rom_enable(rom_en),
    .rom_addr(rom_addr), .ctr_enable(ctr_en), .ctr_rdata(ctr_rdata), .ctl(ctl),
    .option_selected(opt), .aux_trigger(aux));
  tvtrg_video_model video (.clk(clk), .reset(reset), .line_clock(line_clock),
    .field_flag(field_flag));
  // ****************************************************************
  // Clock, bus tasks and expectations
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // One write cycle, held across one rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a; wdata = v; vma = 1'b1; rw = 1'b0;
    @(negedge clk);
    vma = 1'b0; rw = 1'b1;
  endtask
  // Read access; enables are combinational so they are looked at mid-cycle
  task automatic rd_chk(input logic [15:0] a, input logic sel);
    @(negedge clk);
    addr = a; vma = 1'b1; rw = 1'b1;
    #1;
    `CHK("rom_en", sel && a >= 16'h4000 && a <= 16'h7f7f, rom_en)
    `CHK("ctr_en", sel && a >= 16'h7f80 && a <= 16'h7f97 && !a[3], ctr_en)
    `CHK("buf_en", sel && a[14], buf_en)
    `CHK("dir", 1'b1, dir)
    if (rom_en === 1'b1) `CHK("rom_addr", a[12:0], rom_addr)
    @(negedge clk);
    vma = 1'b0;
  endtask
  // Counter read; the data register answers one cycle after the access
  task automatic rd_ctr(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a; vma = 1'b1; rw = 1'b1;
    @(negedge clk);
    vma = 1'b0;
    `CHK("ctr_rdata", e, ctr_rdata)
  endtask
  task automatic sweep(input logic sel);
    for (int k = 0; k < 22; k++)
      rd_chk(k < 10 ? corner[k] : 16'h4000 + 16'($urandom_range(0, 16'h3f97)), sel);
  endtask
  function automatic logic [15:0] mode_addr(input int k);
    if (k % 3 == 0) return 16'h7f9f;
    if (k % 3 == 1) return 16'h7f98 + 16'($urandom_range(0, 6));
    return 16'h7fb8 + 16'($urandom_range(0, 7));
  endfunction
  // Arm and fire one sweep; checks the line index of the trigger against exp_t
  task automatic trial(input int k, input logic [7:0] m, input logic p, input int cnt,
                       input logic c2, input int exp_t);
    int t, got, c;
    logic prev;
    logic [15:0] ca;
    t = 0;
    got = 0;
    ca = c2 ? 16'h7f82 : 16'h7f80;
    wr(mode_addr(k), m);
    if (cnt > 0) begin
      wr(ca, 8'(cnt));
      wr(ca | 16'h0001, 8'h00);
      rd_ctr(ca, 8'(cnt - 1));
    end
    ph = p;
    hold = 1'b1;
    @(negedge clk);
    while (field_flag !== c2) @(negedge clk);
    `CHK("held", 1'b0, aux)
    hold = 1'b0;
    if (cnt > 0) while (field_flag !== !c2) @(negedge clk);
    prev = line_clock;
    for (c = 0; c < 400 && got == 0; c++) begin
      @(negedge clk);
      if (line_clock && !prev) t++;
      prev = line_clock;
      if (aux === 1'b1) got = t;
    end
    `CHK("trig_line", exp_t, got)
    hold = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("cleared", 1'b0, aux)
  endtask
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    n_errors = 0; checks = 0;
    reset = 1'b1; vma = 1'b0; rw = 1'b1; addr = 16'h0000; wdata = 8'h00;
    hold = 1'b1; ph = 1'b1;
    void'($urandom(32'hbb11188b));
    repeat (20) @(negedge clk);
    reset = 1'b0;
    `CHK("opt_rst", 1'b0, opt)
    `CHK("ctl_rst", 8'h00, ctl)
    wr(16'h7f8f, 8'hff);
    `CHK("ctl_desel", 8'h00, ctl)
    sweep(1'b0);
    wr(16'h7fc0 + 16'($urandom_range(0, 16'h3f)), 8'($urandom()) | 8'h20);
    `CHK("opt_on", 1'b1, opt)
    sweep(1'b1);
    for (i = 0; i < 3; i++) begin
      d = 8'($urandom()) | 8'h80;
      wr(i == 0 ? 16'h7f8f : i == 1 ? 16'h7f88 + 16'($urandom_range(0, 6))
                : 16'h7fa8 + 16'($urandom_range(0, 7)), d);
      `CHK("ctl", d, ctl)
    end
    n = $urandom_range(2, 5);
    trial(0, 8'h04, 1'b0, 0, 1'b0, 1);
    trial(1, 8'h00, 1'($urandom()), n, 1'b0, n + 1);
    trial(2, 8'h01, 1'b1, n, 1'b0, n + 1);
    trial(3, 8'h01, 1'b0, n, 1'b0, 0);
    trial(4, 8'h03, 1'b0, 2, 1'b0, 3);
    trial(5, 8'h03, 1'b1, n, 1'b0, 0);
    trial(6, 8'h03, 1'b1, n, 1'b1, n + 1);
    wr(16'h7fff, 8'hdf);
    `CHK("opt_off", 1'b0, opt)
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
